/* File: pmbus_vout_pkg.sv */
package pmbus_vout_pkg;

    // Command codes
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_BUS_FEATURE_REPORT = 8'h19;
    localparam logic [7:0] CMD_OUTPUT_FORMAT_EXPONENT = 8'h20;
    localparam logic [7:0] CMD_OUTPUT_SETPOINT = 8'h21;
    localparam logic [7:0] CMD_OUTPUT_UPPER_LIMIT = 8'h24;
    localparam logic [7:0] CMD_OUTPUT_MARGIN_HIGH = 8'h25;
    localparam logic [7:0] CMD_OUTPUT_MARGIN_LOW = 8'h26;
    localparam logic [7:0] CMD_FEEDBACK_DIVIDER_RATIO = 8'h29;
    localparam logic [7:0] CMD_OUTPUT_LOWER_LIMIT = 8'h2B;

    // Bus_feature_report byte fields
    localparam int CAP_PEC_BIT = 7;
    localparam int CAP_SPEED_LSB = 5;
    localparam int CAP_ALERT_BIT = 4;
    localparam logic [1:0] SPEED_100K = 2'h0;
    localparam logic [1:0] SPEED_1M = 2'h1;
    localparam logic [1:0] SPEED_400K = 2'h2;
    localparam logic [7:0] BUS_FEATURE_REPORT_VALUE = 8'hB0;

    // Mode byte: format in [7:5], exponent in [4:0]
    localparam int MODE_FORMAT_LSB = 5;
    localparam logic [2:0] MODE_FORMAT_DIRECT = 3'h2;
    localparam logic [7:0] OUTPUT_FORMAT_EXPONENT_RESET = 8'h40;

    // Voltage words: 12 writable bits, 2 mV per step
    localparam int VALUE_BITS = 12;
    localparam logic [15:0] OUTPUT_SETPOINT_RESET = 16'h0258;
    localparam logic [15:0] OUTPUT_UPPER_LIMIT_RESET = 16'h0BB8;
    localparam logic [15:0] OUTPUT_UPPER_LIMIT_CEILING = 16'h0BB8;
    localparam logic [15:0] OUTPUT_MARGIN_HIGH_RESET = 16'h02A0;
    localparam logic [15:0] OUTPUT_MARGIN_LOW_RESET = 16'h01FE;
    localparam logic [15:0] FEEDBACK_DIVIDER_RATIO_RESET = 16'h01F4;
    localparam logic [15:0] OUTPUT_LOWER_LIMIT_RESET = 16'h00FA;
    localparam logic [15:0] OUTPUT_LOWER_LIMIT_FLOOR = 16'h00FA;

    // Status bit positions
    localparam int STATUS_WORD_VOUT_BIT = 15;
    localparam int STATUS_VOUT_MAXMIN_BIT = 3;

    // Margin selection
    typedef enum logic [1:0] {MARGIN_NONE, MARGIN_LOW, MARGIN_HIGH} margin_sel_t;

endpackage

/* File: vout_clamp.sv */
`timescale 1ns/100ps
`default_nettype none

module vout_clamp (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Request and limits
    input wire logic [15:0] requested,
    input wire logic [15:0] upper_limit,
    input wire logic [15:0] lower_limit,
    input wire logic [15:0] divider_ratio,
    // Results
    output logic [15:0] target,
    output logic [31:0] reference,
    output logic clamp_high,
    output logic clamp_low
);

    wire logic above = requested > upper_limit;
    wire logic below = requested < lower_limit;
    // Upper limit wins if the limits cross
    wire logic [15:0] next_target = above ? upper_limit : (below ? lower_limit : requested);
    wire logic [31:0] next_reference = next_target * divider_ratio;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            target <= 16'h0000;
            reference <= 32'h00000000;
            clamp_high <= 1'b0;
            clamp_low <= 1'b0;
        end
        else
        begin
            target <= next_target;
            reference <= next_reference;
            clamp_high <= above;
            clamp_low <= below && !above;
        end
    end

endmodule

`default_nettype wire

/* File: pmbus_vout_limit_registers.sv */
// What this block does
// - Bus_feature_report answers a read as one byte; host fetches it with read byte.
// - Bus_feature_report bits 6:5 give bus speed; this device reports 1 MHz (01).
// - Bus_feature_report is read-only, PEC bit7 and alert bit4 set, low nibble zero, 0xB0.
// - Mode byte: direct format in top three bits, exponent in low five, resets 0x40.
// - Setpoint is 16 bits, top four read zero, low twelve writable, resets 0x0258.
// - Feedback reference equals the clamped target (setpoint or margin level) times divider ratio.
// - Request above upper limit is replaced by upper limit, whatever its source.
// - Any clamp sets status-word VOUT bit, max/min warning bit, and alerts host.
// - Upper limit register, 2 mV steps, at most 0x0BB8 and resets there.
// - Margin-high register, 2 mV steps, resets to 0x02A0.
// - Margin-low register, 2 mV steps, resets to 0x01FE.
// - Divider ratio register, 0.001 steps, resets 0x01F4; host matches real divider.
// - Request below lower limit, and not above upper limit, is replaced by lower limit.
// - Lower limit register, 2 mV steps, at least 0x00FA and resets there.
// - Flags stay set until clear-faults; persisting condition reasserts them at once.
`timescale 1ns/100ps
`default_nettype none

module pmbus_vout_limit_registers (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Decoded command port from the bus transaction layer
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    // Read answer
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic rsp_two_bytes,
    output logic rsp_unsupported,
    // Margin selection from the operation logic
    input wire logic [1:0] margin_sel,
    // Loop outputs
    output logic [15:0] vout_target,
    output logic [31:0] vout_reference,
    // Status and alert
    output logic status_word_vout,
    output logic status_vout_maxmin,
    output logic alert_n
);

    function automatic logic [15:0] low_bits(input logic [15:0] value);
        low_bits = {4'h0, value[pmbus_vout_pkg::VALUE_BITS-1:0]};
    endfunction

    logic [15:0] output_setpoint;
    logic [15:0] output_upper_limit;
    logic [15:0] output_margin_high;
    logic [15:0] output_margin_low;
    logic [15:0] feedback_divider_ratio;
    logic [15:0] output_lower_limit;
    logic clamp_high;
    logic clamp_low;

    // Bus_feature_report fields
    wire logic cap_pec = 1'b1;
    wire logic [1:0] cap_speed = pmbus_vout_pkg::SPEED_1M;
    wire logic cap_alert = 1'b1;
    wire logic [3:0] cap_spare = 4'h0;
    wire logic [7:0] bus_feature_report = {cap_pec, cap_speed, cap_alert, cap_spare};
    wire logic [2:0] mode_format = pmbus_vout_pkg::MODE_FORMAT_DIRECT;
    wire logic [4:0] mode_exponent = pmbus_vout_pkg::OUTPUT_FORMAT_EXPONENT_RESET[4:0];
    wire logic [7:0] output_format_exponent = {mode_format, mode_exponent};

    wire logic wr = cmd_valid && cmd_write;
    wire logic rd = cmd_valid && !cmd_write;
    wire logic [15:0] wvalue = low_bits(cmd_wdata);
    wire logic wr_setpoint = wr && cmd_code == pmbus_vout_pkg::CMD_OUTPUT_SETPOINT;
    wire logic wr_upper = wr && cmd_code == pmbus_vout_pkg::CMD_OUTPUT_UPPER_LIMIT;
    wire logic wr_mhigh = wr && cmd_code == pmbus_vout_pkg::CMD_OUTPUT_MARGIN_HIGH;
    wire logic wr_mlow = wr && cmd_code == pmbus_vout_pkg::CMD_OUTPUT_MARGIN_LOW;
    wire logic wr_ratio = wr && cmd_code == pmbus_vout_pkg::CMD_FEEDBACK_DIVIDER_RATIO;
    wire logic wr_lower = wr && cmd_code == pmbus_vout_pkg::CMD_OUTPUT_LOWER_LIMIT;
    wire logic clear_faults = wr && cmd_code == pmbus_vout_pkg::CMD_CLEAR_FAULTS;

    // Limit registers hold within their permitted range
    wire logic [15:0] next_upper = (wvalue > pmbus_vout_pkg::OUTPUT_UPPER_LIMIT_CEILING)
        ? pmbus_vout_pkg::OUTPUT_UPPER_LIMIT_CEILING : wvalue;
    wire logic [15:0] next_lower = (wvalue < pmbus_vout_pkg::OUTPUT_LOWER_LIMIT_FLOOR)
        ? pmbus_vout_pkg::OUTPUT_LOWER_LIMIT_FLOOR : wvalue;

    // Source of the request: nominal or a margin level
    wire logic [15:0] requested =
        (margin_sel == pmbus_vout_pkg::MARGIN_HIGH) ? output_margin_high :
        (margin_sel == pmbus_vout_pkg::MARGIN_LOW) ? output_margin_low : output_setpoint;

    // Read decode
    logic [15:0] next_rdata;
    logic next_two;
    logic next_unsup;
    always_comb
    begin
        next_rdata = 16'h0000;
        next_two = 1'b1;
        next_unsup = 1'b0;
        unique case (cmd_code)
            pmbus_vout_pkg::CMD_BUS_FEATURE_REPORT:
            begin
                next_rdata = {8'h00, bus_feature_report};
                next_two = 1'b0;
            end
            pmbus_vout_pkg::CMD_OUTPUT_FORMAT_EXPONENT:
            begin
                next_rdata = {8'h00, output_format_exponent};
                next_two = 1'b0;
            end
            pmbus_vout_pkg::CMD_OUTPUT_SETPOINT: next_rdata = low_bits(output_setpoint);
            pmbus_vout_pkg::CMD_OUTPUT_UPPER_LIMIT: next_rdata = low_bits(output_upper_limit);
            pmbus_vout_pkg::CMD_OUTPUT_MARGIN_HIGH: next_rdata = low_bits(output_margin_high);
            pmbus_vout_pkg::CMD_OUTPUT_MARGIN_LOW: next_rdata = low_bits(output_margin_low);
            pmbus_vout_pkg::CMD_FEEDBACK_DIVIDER_RATIO:
                next_rdata = low_bits(feedback_divider_ratio);
            pmbus_vout_pkg::CMD_OUTPUT_LOWER_LIMIT: next_rdata = low_bits(output_lower_limit);
            default:
            begin
                next_two = 1'b0;
                next_unsup = 1'b1;
            end
        endcase
    end

    // Set wins over clear-faults
    wire logic clamp_event = clamp_high || clamp_low;
    wire logic next_word_vout = clamp_event || (status_word_vout && !clear_faults);
    wire logic next_maxmin = clamp_event || (status_vout_maxmin && !clear_faults);

    // Writable registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            output_setpoint <= pmbus_vout_pkg::OUTPUT_SETPOINT_RESET;
        end
        else if (wr_setpoint)
        begin
            output_setpoint <= wvalue;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            output_upper_limit <= pmbus_vout_pkg::OUTPUT_UPPER_LIMIT_RESET;
        end
        else if (wr_upper)
        begin
            output_upper_limit <= next_upper;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            output_margin_high <= pmbus_vout_pkg::OUTPUT_MARGIN_HIGH_RESET;
        end
        else if (wr_mhigh)
        begin
            output_margin_high <= wvalue;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            output_margin_low <= pmbus_vout_pkg::OUTPUT_MARGIN_LOW_RESET;
        end
        else if (wr_mlow)
        begin
            output_margin_low <= wvalue;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            feedback_divider_ratio <= pmbus_vout_pkg::FEEDBACK_DIVIDER_RATIO_RESET;
        end
        else if (wr_ratio)
        begin
            feedback_divider_ratio <= wvalue;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            output_lower_limit <= pmbus_vout_pkg::OUTPUT_LOWER_LIMIT_RESET;
        end
        else if (wr_lower)
        begin
            output_lower_limit <= next_lower;
        end
    end

    // Read answer, one cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_valid <= 1'b0;
        end
        else
        begin
            rsp_valid <= rd;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_data <= 16'h0000;
        end
        else
        begin
            rsp_data <= rd ? next_rdata : 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_two_bytes <= 1'b0;
        end
        else
        begin
            rsp_two_bytes <= rd && next_two;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_unsupported <= 1'b0;
        end
        else
        begin
            rsp_unsupported <= rd && next_unsup;
        end
    end

    // Sticky status and alert
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_word_vout <= 1'b0;
        end
        else
        begin
            status_word_vout <= next_word_vout;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_vout_maxmin <= 1'b0;
        end
        else
        begin
            status_vout_maxmin <= next_maxmin;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            alert_n <= 1'b1;
        end
        else
        begin
            alert_n <= !(next_word_vout || next_maxmin);
        end
    end

    // Clamp and reference
    vout_clamp clamp_unit (
        .clk(clk),
        .resetn(resetn),
        .requested(requested),
        .upper_limit(output_upper_limit),
        .lower_limit(output_lower_limit),
        .divider_ratio(feedback_divider_ratio),
        .target(vout_target),
        .reference(vout_reference),
        .clamp_high(clamp_high),
        .clamp_low(clamp_low)
    );

endmodule

`default_nettype wire

/* File: pmbus_vout_limit_registers_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module pmbus_vout_limit_registers_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    // Read answer
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic rsp_two_bytes,
    input wire logic rsp_unsupported,
    // Loop and status
    input wire logic [1:0] margin_sel,
    input wire logic [15:0] vout_target,
    input wire logic [31:0] vout_reference,
    input wire logic status_word_vout,
    input wire logic status_vout_maxmin,
    input wire logic alert_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire rd_req = cmd_valid && !cmd_write;
    wire clear_req = cmd_valid && cmd_write && cmd_code == 8'h03;
    a_read_answer_next: assert property (rd_req |=> rsp_valid) else $error("read unanswered");
    a_feature_byte: assert property (rd_req && cmd_code == 8'h19 |=>
        rsp_data == 16'h00B0 && !rsp_two_bytes) else $error("feature byte wrong");
    a_mode_byte: assert property (rd_req && cmd_code == 8'h20 |=> rsp_data == 16'h0040)
        else $error("mode byte wrong");
    a_word_top_zero: assert property (rsp_valid |-> rsp_data[15:12] == 4'h0)
        else $error("upper bits not zero");
    a_target_ceiling: assert property (vout_target <= 16'h0BB8) else $error("target high");
    a_target_floor: assert property ($past(resetn) |-> vout_target >= 16'h00FA)
        else $error("target low");
    a_alert_follows_flags: assert property (alert_n == !(status_word_vout || status_vout_maxmin))
        else $error("alert wrong");
    a_flags_paired: assert property (status_word_vout == status_vout_maxmin)
        else $error("flags differ");
    a_flag_sticky: assert property (status_vout_maxmin && !clear_req |=> status_vout_maxmin)
        else $error("flag dropped");
endmodule
bind pmbus_vout_limit_registers pmbus_vout_limit_registers_checker u_checker (.clk(clk),
    .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_two_bytes(rsp_two_bytes), .rsp_unsupported(rsp_unsupported), .margin_sel(margin_sel),
    .vout_target(vout_target), .vout_reference(vout_reference),
    .status_word_vout(status_word_vout), .status_vout_maxmin(status_vout_maxmin),
    .alert_n(alert_n));
`default_nettype wire

/* File: pmbus_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pmbus_host_model (
    // Clock
    input wire logic clk,
    // Command port
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    // Read answer
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic rsp_two_bytes,
    input wire logic rsp_unsupported
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'hA5;
        cmd_wdata = 16'h5A5A;
    end
    task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = data;
        @(negedge clk);
        cmd_valid = 1'b0;
        // Idle lines carry junk
        cmd_code = ~code;
        cmd_wdata = ~data;
    endtask
    task automatic read(input logic [7:0] code, output logic [15:0] data, output logic word,
        output logic bad, output logic seen);
        send(1'b0, code, 16'hFFFF);
        data = rsp_data;
        word = rsp_two_bytes;
        bad = rsp_unsupported;
        seen = rsp_valid;
    endtask
endmodule
`default_nettype wire

/* File: pmbus_vout_limit_registers_test.sv */
`timescale 1ns/100ps
`default_nettype none
module pmbus_vout_limit_registers_test;
    logic clk;
    logic resetn;
    logic [1:0] margin_sel;
    logic [15:0] d;
    logic w, b, s;
    int n_errors;
    int tests_run;
    wire logic cmd_valid, cmd_write, rsp_valid, rsp_two_bytes, rsp_unsupported;
    wire logic status_word_vout, status_vout_maxmin, alert_n;
    wire logic [7:0] cmd_code;
    wire logic [15:0] cmd_wdata, rsp_data, vout_target;
    wire logic [31:0] vout_reference;
    pmbus_vout_limit_registers u_pmbus_vout_limit_registers (.clk(clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_two_bytes(rsp_two_bytes), .rsp_unsupported(rsp_unsupported),
        .margin_sel(margin_sel), .vout_target(vout_target), .vout_reference(vout_reference),
        .status_word_vout(status_word_vout), .status_vout_maxmin(status_vout_maxmin),
        .alert_n(alert_n));
    pmbus_host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_two_bytes(rsp_two_bytes), .rsp_unsupported(rsp_unsupported));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Flags are {valid, word, unsupported}
    task automatic rd_chk(input string name, input logic [7:0] code, input logic [15:0] exp,
        input logic [2:0] flags);
        u_host.read(code, d, w, b, s);
        check(name, {13'h0, s, w, b, d}, {13'h0, flags, exp});
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
    initial
    begin
        n_errors = 0;
        tests_run = 0;
        resetn = 1'b0;
        margin_sel = 2'h0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        rd_chk("feature", 8'h19, 16'h00B0, 3'h4);
        rd_chk("mode", 8'h20, 16'h0040, 3'h4);
        rd_chk("setpoint", 8'h21, 16'h0258, 3'h6);
        rd_chk("upper", 8'h24, 16'h0BB8, 3'h6);
        rd_chk("margin_high", 8'h25, 16'h02A0, 3'h6);
        rd_chk("margin_low", 8'h26, 16'h01FE, 3'h6);
        rd_chk("ratio", 8'h29, 16'h01F4, 3'h6);
        rd_chk("lower", 8'h2B, 16'h00FA, 3'h6);
        check("reference", vout_reference, 32'h0258 * 32'h01F4);
        $display("test reset_values done");
        u_host.send(1'b1, 8'h19, 16'h00FF);
        rd_chk("feature_ro", 8'h19, 16'h00B0, 3'h4);
        u_host.send(1'b1, 8'h21, 16'h1234);
        rd_chk("setpoint_top", 8'h21, 16'h0234, 3'h6);
        u_host.send(1'b1, 8'h24, 16'hFFFF);
        rd_chk("upper_cap", 8'h24, 16'h0BB8, 3'h6);
        u_host.send(1'b1, 8'h2B, 16'h0010);
        rd_chk("lower_cap", 8'h2B, 16'h00FA, 3'h6);
        rd_chk("unmapped", 8'h30, 16'h0000, 3'h5);
        u_host.send(1'b1, 8'h29, 16'h03E8);
        u_host.send(1'b1, 8'h21, 16'h0258);
        repeat (2) @(negedge clk);
        check("reference_new", vout_reference, 32'h0258 * 32'h03E8);
        $display("test access done");
        u_host.send(1'b1, 8'h24, 16'h0300);
        u_host.send(1'b1, 8'h21, 16'h0400);
        repeat (3) @(negedge clk);
        check("clamp_high", {16'h0, vout_target}, 32'h0300);
        check("flags_set", {status_word_vout, status_vout_maxmin, alert_n}, 3'h6);
        u_host.send(1'b1, 8'h03, 16'h0000);
        repeat (2) @(negedge clk);
        check("flags_held", {status_word_vout, status_vout_maxmin, alert_n}, 3'h6);
        u_host.send(1'b1, 8'h2B, 16'h0200);
        margin_sel = 2'h1;
        repeat (3) @(negedge clk);
        check("clamp_low", {16'h0, vout_target}, 32'h0200);
        margin_sel = 2'h2;
        repeat (3) @(negedge clk);
        check("flags_sticky", {status_word_vout, status_vout_maxmin, alert_n}, 3'h6);
        u_host.send(1'b1, 8'h03, 16'h0000);
        repeat (2) @(negedge clk);
        check("margin_high", {16'h0, vout_target}, 32'h02A0);
        check("flags_clear", {status_word_vout, status_vout_maxmin, alert_n}, 3'h1);
        $display("test clamp done");
        end_of_test();
    end
endmodule
`default_nettype wire
